// ==== adc_regs_params.svh ====
// Register offsets, field positions, reset values and timing for the converter register block.
`ifndef ADC_REGS_PARAMS_SVH
`define ADC_REGS_PARAMS_SVH

`define OFS_MISC       8'h77
`define OFS_RES_LOW    8'h78
`define OFS_RES_HIGH   8'h79
`define OFS_CTRL_A     8'h7a
`define OFS_CTRL_B     8'h7b
`define OFS_CHAN_SEL   8'h7c
`define OFS_DIN_OFF_A  8'h7e
`define OFS_DIN_OFF_B  8'h7f

`define CA_ENABLE      7
`define CA_START       6
`define CA_AUTO        5
`define CA_DONE        4
`define CA_IRQ_EN      3
`define CB_BIPOLAR     7
`define CS_LEFT_ALIGN  5
`define MISC_EXT_REF   2
`define MISC_INT_REF   1
`define MISC_ISRC      0

`define CB_WMASK       8'hf7
`define DB_WMASK       8'h70
`define MISC_WMASK     8'h07
`define REG_RESET      8'h00
`define RES_RESET      10'h000
`define RES_FULL_SCALE 10'h3ff
`define TRIG_FREE_RUN  3'h0
`define START_PULSE_CYCLES 1

`endif

// ==== adc_regs_pkg.sv ====
// Types for the converter register block.
package adc_regs_pkg;

   typedef enum logic {
      lock_open,
      lock_held
   } lock_t;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] chan_sel;
      logic [7:0] din_off_a;
      logic [7:0] din_off_b;
      logic [7:0] misc;
      logic [9:0] result;
      lock_t      lock;
      logic       busy;
      logic       trig_prev;
      logic       start_pulse;
      logic [7:0] rdata;
      logic [10:0] pin_read;
   } state_t;

endpackage : adc_regs_pkg

// ==== adc_result_regs.sv ====
// Register side of the 10-bit converter: result bytes, triggering, input disables, reference bits.
`timescale 1ns/10ps
`include "adc_regs_params.svh"

// Register map, byte wide, all reset to zero:
//   0x77  reference and current source enables, bits 2:0 only.
//   0x78  result low byte, read only; reading it freezes the result.
//   0x79  result high byte, read only; reading it releases the freeze.
//   0x7a  control A: enable, start/busy, auto trigger, done flag, irq enable, prescale.
//   0x7b  control B: bipolar select, comparator bits, trigger source; bit 3 reads zero.
//   0x7c  channel select: left alignment and channel/gain bits.
//   0x7d  not mapped.
//   0x7e  digital input disables for pins 7 to 0.
//   0x7f  digital input disables for pins 10 to 8 in bits 6:4.
// Unmapped offsets read zero and ignore writes. The result freeze is only lifted by a
// high-byte read, so software that reads the low byte alone keeps every later result
// out until it reads the high byte; that is the price of a coherent two-byte read.
//
// Trigger handling: the flag of the selected source is registered every cycle, and a start
// is raised when the flag seen now is high and the one registered last cycle was low. Since
// the registered copy belongs to whatever source was selected then, moving the selection
// from a quiet source to a raised one counts as a rising edge. A start that arrives while a
// conversion runs is dropped, except in the completion cycle itself, so free running mode
// can restart without a gap.
//
// Result format: unipolar results are plain ten-bit values and clamp to full scale when the
// negative input is the larger; bipolar results carry a sign and nine magnitude bits in
// two's complement. The format is fixed when the result is stored, while the byte
// alignment is applied only on the way out, so it may change at any time.
//
// Done flag: set together with a stored result, cleared by interrupt entry or by writing a
// one to it. When a completion and a clear meet in one cycle the completion wins, so an
// interrupt is never lost; a result dropped under the freeze raises no flag, which is why
// software that forgets the high-byte read sees its converter fall silent.
//
// Reads: the read data register is loaded only in the cycle after a read strobe and is
// zero otherwise, so a late sample shows zero rather than stale data. A conversion that
// completes in the same cycle as a low-byte read is dropped, which keeps the two bytes
// of one read from coming from two different conversions.

module adc_result_regs #(
   parameter int RES_W = 10,
   parameter int PINS  = 11
) (
   input  wire logic             clk,              // System clock, 100 MHz.
   input  wire logic             reset,            // Synchronous reset, active high.
   input  wire logic [7:0]       addr,             // Register address.
   input  wire logic [7:0]       wdata,            // Write data.
   input  wire logic             wr,               // Write strobe.
   input  wire logic             rd,               // Read strobe.
   output logic      [7:0]       rdata,            // Read data, valid the cycle after rd.
   input  wire logic             conv_done,        // Analog core finished a conversion.
   input  wire logic [RES_W-1:0] conv_mag,         // Raw magnitude from the analog core.
   input  wire logic             conv_neg,         // Negative input exceeded positive input.
   input  wire logic             done_flag_ack,    // Interrupt entry clears the done flag.
   input  wire logic [7:1]       trig_flags,       // Source flags, index equals trigger code.
   input  wire logic [PINS-1:0]  pin_in,           // Raw digital levels of the analog pins.
   output logic [PINS-1:0]       pin_read,         // Pin levels as software sees them.
   output logic [PINS-1:0]       pin_buffer_off,   // Digital input buffer disables.
   output logic                  conv_start,       // One-cycle start to the analog core.
   output logic                  converter_enable, // Analog core powered.
   output logic                  conv_busy,        // Conversion in progress.
   output logic                  conversion_done_flag, // Done flag, level.
   output logic                  done_irq_enable,  // Done interrupt enable bit.
   output logic [2:0]            prescale_sel,     // Core clock divider select.
   output logic [4:0]            channel_mux_bits, // Channel and gain select.
   output logic                  bipolar_mode_select,  // Bipolar gain stage mode.
   output logic                  ext_ref_input_enable, // Reference from input pin.
   output logic                  int_ref_output_enable, // Internal reference to output pin.
   output logic                  current_source_enable  // Current source on.
);
   import adc_regs_pkg::*;

   state_t s_r;
   state_t s_nxt;

   logic [RES_W-1:0] new_result;
   logic [8:0]       bip_mag;
   logic             trig_now;
   logic             auto_on;
   logic             sel_free;
   logic             start_req;
   logic             take_result;
   logic [7:0]       low_view;
   logic [7:0]       high_view;
   logic [2:0]       trig_sel;
   logic             rd_low_hit;
   logic             wr_ctrl_a_hit;
   logic [RES_W-1:0] bip_pos;
   logic [RES_W-1:0] bip_neg;
   logic [PINS-1:0]  pin_off_view;
   logic [PINS-1:0]  pin_masked;

   // The disables are applied bit by bit; a disabled pin reads zero whatever
   // level it carries, so an analog voltage never reaches software as a bit.
   assign pin_off_view = {s_r.din_off_b[6:4], s_r.din_off_a};
   for (genvar g = 0; g < PINS; g++) begin : g_pin_mask
      assign pin_masked[g] = pin_in[g] & ~pin_off_view[g];
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.start_pulse = 1'b0;
      s_nxt.rdata = `REG_RESET;
      trig_sel = s_r.ctrl_b[2:0];
      sel_free = (trig_sel == `TRIG_FREE_RUN);
      auto_on = s_r.ctrl_a[`CA_AUTO];
      rd_low_hit = rd && (addr == `OFS_RES_LOW);
      wr_ctrl_a_hit = wr && (addr == `OFS_CTRL_A);

      // Bipolar: sign plus nine magnitude bits, folded into two's complement.
      bip_mag = conv_mag[8:0];
      bip_pos = RES_W'({1'b0, bip_mag});
      bip_neg = RES_W'(-bip_pos);
      if (s_r.ctrl_b[`CB_BIPOLAR]) begin
         new_result = conv_neg ? bip_neg : bip_pos;
      end else begin
         new_result = conv_neg ? `RES_FULL_SCALE : conv_mag;
      end

      // Free running has no flag signal, so selecting it can never make an edge,
      // even while the done flag is set.
      case (trig_sel)
         // Comparator.
         3'h1: begin
            trig_now = trig_flags[1];
         end
         // External interrupt 0.
         3'h2: begin
            trig_now = trig_flags[2];
         end
         // Timer 1 compare A.
         3'h3: begin
            trig_now = trig_flags[3];
         end
         // Timer 1 overflow.
         3'h4: begin
            trig_now = trig_flags[4];
         end
         // Timer 1 compare B.
         3'h5: begin
            trig_now = trig_flags[5];
         end
         // Timer 1 capture.
         3'h6: begin
            trig_now = trig_flags[6];
         end
         // Watchdog.
         3'h7: begin
            trig_now = trig_flags[7];
         end
         default: begin
            trig_now = 1'b0;
         end
      endcase
      s_nxt.trig_prev = trig_now;

      // Presentation is formed from the stored result at read time, so an
      // alignment change shows at once, even mid-conversion.
      if (s_r.chan_sel[`CS_LEFT_ALIGN]) begin
         high_view = s_r.result[9:2];
         low_view = {s_r.result[1:0], 6'h00};
      end else begin
         high_view = {6'h00, s_r.result[9:8]};
         low_view = s_r.result[7:0];
      end

      // A low-byte read in the completion cycle wins: the byte just read and the
      // byte read next must come from the same result.
      take_result = conv_done && s_r.busy && (s_r.lock == lock_open) && !rd_low_hit;
      start_req = 1'b0;

      // Completion: result and flag update together.
      // A completion seen while idle is a stray pulse and is ignored.
      if (conv_done && s_r.busy) begin
         s_nxt.busy = 1'b0;
      end
      if (take_result) begin
         s_nxt.result = new_result;
      end

      // Done flag: clear by ack or write-one, set wins over clear.
      if (done_flag_ack) begin
         s_nxt.ctrl_a[`CA_DONE] = 1'b0;
      end

      // Register writes.
      // Reserved bits are dropped on the way in, so they always read back as zero.
      if (wr) begin
         case (addr)
            `OFS_CTRL_A: begin
               s_nxt.ctrl_a[7] = wdata[7];
               s_nxt.ctrl_a[5] = wdata[5];
               s_nxt.ctrl_a[3:0] = wdata[3:0];
               if (wdata[`CA_DONE]) begin
                  s_nxt.ctrl_a[`CA_DONE] = 1'b0;
               end
               if (wdata[`CA_START] && wdata[`CA_ENABLE]) begin
                  start_req = 1'b1;
               end
            end
            `OFS_CTRL_B: begin
               s_nxt.ctrl_b = wdata & `CB_WMASK;
            end
            `OFS_CHAN_SEL: begin
               s_nxt.chan_sel = wdata;
            end
            `OFS_DIN_OFF_A: begin
               s_nxt.din_off_a = wdata;
            end
            `OFS_DIN_OFF_B: begin
               s_nxt.din_off_b = wdata & `DB_WMASK;
            end
            `OFS_MISC: begin
               s_nxt.misc = wdata & `MISC_WMASK;
            end
            default: begin
            end
         endcase
      end

      if (take_result) begin
         s_nxt.ctrl_a[`CA_DONE] = 1'b1;
      end

      // Auto trigger: the edge is taken against the flag of the source selected
      // last cycle, so a switch onto a set flag looks like a rising edge.
      if (auto_on && s_r.ctrl_a[`CA_ENABLE]) begin
         if (trig_now && !s_r.trig_prev) begin
            start_req = 1'b1;
         end
         if (sel_free && take_result) begin
            start_req = 1'b1;
         end
      end

      // A start while busy is absorbed unless the conversion completes this cycle; the running conversion is not restarted.
      if (start_req && (!s_r.busy || (conv_done && s_r.busy))) begin
         s_nxt.busy = 1'b1;
         s_nxt.start_pulse = 1'b1;
      end
      // Turning the converter off ends a running conversion; unless it completes in that
      // same cycle, its result never arrives, so no done flag follows.
      if (wr_ctrl_a_hit && !wdata[`CA_ENABLE]) begin
         s_nxt.busy = 1'b0;
         s_nxt.start_pulse = 1'b0;
      end

      // Reads: data stand in the next cycle only.
      if (rd) begin
         case (addr)
            `OFS_CTRL_A: begin
               s_nxt.rdata = s_r.ctrl_a;
               // The start bit reads back as busy, so software can poll it.
               s_nxt.rdata[`CA_START] = s_r.busy;
            end
            `OFS_CTRL_B: begin
               s_nxt.rdata = s_r.ctrl_b;
            end
            `OFS_CHAN_SEL: begin
               s_nxt.rdata = s_r.chan_sel;
            end
            `OFS_DIN_OFF_A: begin
               s_nxt.rdata = s_r.din_off_a;
            end
            `OFS_DIN_OFF_B: begin
               s_nxt.rdata = s_r.din_off_b;
            end
            `OFS_MISC: begin
               s_nxt.rdata = s_r.misc;
            end
            `OFS_RES_LOW: begin
               s_nxt.rdata = low_view;
               s_nxt.lock = lock_held;
            end
            `OFS_RES_HIGH: begin
               s_nxt.rdata = high_view;
               s_nxt.lock = lock_open;
            end
            default: begin
               s_nxt.rdata = `REG_RESET;
            end
         endcase
      end

      // Disabled buffers force the pin read to zero.
      s_nxt.pin_read = pin_masked;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         // One register holds all state, so reset clears every bit at once.
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Every output is a bit of the registered state, with no path from an input.
   assign rdata                 = s_r.rdata;
   assign pin_read              = s_r.pin_read;
   assign pin_buffer_off        = pin_off_view;
   assign conv_start            = s_r.start_pulse;
   assign converter_enable      = s_r.ctrl_a[`CA_ENABLE];
   assign conv_busy             = s_r.busy;
   assign conversion_done_flag  = s_r.ctrl_a[`CA_DONE];
   assign done_irq_enable       = s_r.ctrl_a[`CA_IRQ_EN];
   assign prescale_sel          = s_r.ctrl_a[2:0];
   assign channel_mux_bits      = s_r.chan_sel[4:0];
   assign bipolar_mode_select   = s_r.ctrl_b[`CB_BIPOLAR];
   assign ext_ref_input_enable  = s_r.misc[`MISC_EXT_REF];
   assign int_ref_output_enable = s_r.misc[`MISC_INT_REF];
   assign current_source_enable = s_r.misc[`MISC_ISRC];

endmodule : adc_result_regs

// ==== adc_regs_chk.sv ====
// Port-level assertions for the converter register block.
`timescale 1ns/10ps
module adc_regs_chk #(
   parameter int PINS = 11
) (
   input wire logic            clk,                  // Clock.
   input wire logic            reset,                // Reset.
   input wire logic [7:0]      addr,                 // Address.
   input wire logic [7:0]      wdata,                // Write data.
   input wire logic            wr,                   // Write.
   input wire logic            rd,                   // Read.
   input wire logic [7:0]      rdata,                // Read data.
   input wire logic            conv_done,            // Done.
   input wire logic            done_flag_ack,        // Ack.
   input wire logic [PINS-1:0] pin_read,             // Pins.
   input wire logic [PINS-1:0] pin_buffer_off,       // Disables.
   input wire logic            conv_start,           // Start.
   input wire logic            conv_busy,            // Busy.
   input wire logic            converter_enable,     // Enable.
   input wire logic            conversion_done_flag, // Flag.
   input wire logic            ext_ref_input_enable, // Ref in.
   input wire logic            int_ref_output_enable // Ref out.
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_ctrl_b_res: assert property (rd && addr == 8'h7b |=> rdata[3] == 1'b0)
      else $error("control b reserved bit read back set");
   a_misc_res: assert property (rd && addr == 8'h77 |=> rdata[7:3] == 5'h00)
      else $error("misc reserved bits read back set");
   a_pin_mask: assert property ((pin_read & $past(pin_buffer_off)) == '0)
      else $error("disabled pin reads one");
   a_off_b_map: assert property (wr && addr == 8'h7f |=> pin_buffer_off[10:8] == $past(wdata[6:4]))
      else $error("upper pin disables wrong");
   a_ref_bits: assert property (wr && addr == 8'h77 |=> {ext_ref_input_enable, int_ref_output_enable} == $past(wdata[2:1]))
      else $error("reference enables wrong");
   a_busy_cause: assert property ($rose(conv_busy) |-> conv_start)
      else $error("busy without start");
   a_start_enable: assert property (conv_start |-> converter_enable && conv_busy)
      else $error("start while disabled");
   a_flag_cause: assert property ($rose(conversion_done_flag) |-> $past(conv_done) && $past(conv_busy))
      else $error("done flag without completion");
   a_ack_clear: assert property (done_flag_ack && !conv_done |=> !conversion_done_flag)
      else $error("done flag kept after ack");
endmodule : adc_regs_chk

// ==== analog_core_model.sv ====
// Behavioural analog core answering each start with one finished conversion.
`timescale 1ns/10ps
module analog_core_model #(
   parameter int DLY = 5
) (
   input  wire logic       clk,        // Clock.
   input  wire logic       reset,      // Reset.
   input  wire logic       conv_start, // Start pulse.
   input  wire logic [9:0] mag_set,    // Magnitude to return.
   input  wire logic       neg_set,    // Sign flag to return.
   output logic            conv_done,  // Completion pulse.
   output logic [9:0]      conv_mag,   // Magnitude.
   output logic            conv_neg    // Sign flag.
);
   int cnt;
   // Data toggle outside the done cycle so a mistimed sample is caught.
   always @(posedge clk) begin
      conv_done <= cnt == 1;
      conv_mag  <= (cnt == 1) ? mag_set : ~conv_mag;
      conv_neg  <= (cnt == 1) ? neg_set : ~conv_neg;
      if (conv_start)
         cnt <= DLY;
      else if (cnt != 0)
         cnt <= cnt - 1;
      if (reset) begin
         cnt       <= 0;
         conv_done <= 1'b0;
         conv_mag  <= 10'h000;
         conv_neg  <= 1'b0;
      end
   end
endmodule : analog_core_model

// ==== test_adc_result_regs.sv ====
// Self-checking bench for the converter register block.
`timescale 1ns/10ps
module test_adc_result_regs;
   logic        clk, reset, wr, rd, conv_done, conv_neg, done_flag_ack, conv_start, neg_set;
   logic        conv_busy, done_flag, ext_ref, int_ref, bipolar, cen, irq_en, isrc;
   logic [2:0]  psel;
   logic [4:0]  mux;
   logic [7:0]  addr, wdata, rdata;
   logic [9:0]  conv_mag, mag_set;
   logic [7:1]  trig_flags;
   logic [10:0] pin_in, pin_read, pin_off;
   logic [7:0]  regs [9] = '{8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f};
   int          mismatches = 0, total_checks = 0, i;

   adc_result_regs dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .conv_done(conv_done), .conv_mag(conv_mag), .conv_neg(conv_neg),
      .done_flag_ack(done_flag_ack), .trig_flags(trig_flags), .pin_in(pin_in),
      .pin_read(pin_read), .pin_buffer_off(pin_off), .conv_start(conv_start),
      .converter_enable(cen), .conv_busy(conv_busy), .conversion_done_flag(done_flag),
      .done_irq_enable(irq_en), .prescale_sel(psel), .channel_mux_bits(mux),
      .bipolar_mode_select(bipolar), .ext_ref_input_enable(ext_ref),
      .int_ref_output_enable(int_ref), .current_source_enable(isrc));
   analog_core_model core (.clk(clk), .reset(reset), .conv_start(conv_start), .mag_set(mag_set),
      .neg_set(neg_set), .conv_done(conv_done), .conv_mag(conv_mag), .conv_neg(conv_neg));

   task automatic wrap_up;
      if (mismatches == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk({3'b000, rdata}, {3'b000, exp});
   endtask : rd_chk
   // Bounded wait: with want set, a start must appear and busy must drop within 40 cycles; with want clear, they must not.
   task automatic wait_conv(input logic want);
      logic seen;
      int   n;
      seen = 1'b0;
      for (n = 0; n < 40; n++) begin
         #1;
         if (conv_start === 1'b1) seen = 1'b1;
         if (seen && conv_busy === 1'b0) break;
         @(posedge clk);
      end
      chk({10'h000, seen && n < 40}, {10'h000, want});
      if (n == 40 && want) wrap_up();
   endtask : wait_conv

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      reset = 1'b1;
      {wr, rd, done_flag_ack, neg_set} = 4'h0;
      {addr, wdata, mag_set, trig_flags} = '0;
      pin_in = 11'h7ff;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      wr_reg(8'h7d, 8'hff);
      foreach (regs[k]) rd_chk(regs[k], 8'h00);
      wr_reg(8'h7e, 8'h8f);
      wr_reg(8'h7f, 8'h70);
      rd_chk(8'h7f, 8'h70);
      chk(pin_read, 11'h070);
      wr_reg(8'h77, 8'h03);
      rd_chk(8'h77, 8'h03);
      chk({9'h000, ext_ref, int_ref}, 11'h001);
      wr_reg(8'h77, 8'h04);
      rd_chk(8'h77, 8'h04);
      chk({9'h000, ext_ref, int_ref}, 11'h002);
      wr_reg(8'h7b, 8'hf7);
      rd_chk(8'h7b, 8'hf7);
      chk({10'h000, bipolar}, 11'h001);
      wr_reg(8'h7b, 8'h00);
      mag_set <= 10'h2a5;
      wr_reg(8'h7a, 8'hc0);
      wait_conv(1'b1);
      rd_chk(8'h78, 8'ha5);
      rd_chk(8'h79, 8'h02);
      wr_reg(8'h7c, 8'h20);
      rd_chk(8'h79, 8'ha9);
      rd_chk(8'h78, 8'h40);
      wr_reg(8'h7a, 8'h90);
      #1 chk({10'h000, done_flag}, 11'h000);
      mag_set <= 10'h155;
      wr_reg(8'h7a, 8'hc0);
      wait_conv(1'b1);
      chk({10'h000, done_flag}, 11'h000);
      rd_chk(8'h79, 8'ha9);
      wr_reg(8'h7a, 8'hc0);
      wait_conv(1'b1);
      rd_chk(8'h79, 8'h55);
      @(posedge clk) done_flag_ack <= 1'b1;
      @(posedge clk) done_flag_ack <= 1'b0;
      #1 chk({10'h000, done_flag}, 11'h000);
      wr_reg(8'h7c, 8'h00);
      neg_set <= 1'b1;
      wr_reg(8'h7a, 8'hc0);
      wait_conv(1'b1);
      rd_chk(8'h78, 8'hff);
      rd_chk(8'h79, 8'h03);
      wr_reg(8'h7b, 8'h80);
      mag_set <= 10'h005;
      wr_reg(8'h7a, 8'hc0);
      wait_conv(1'b1);
      rd_chk(8'h78, 8'hfb);
      rd_chk(8'h79, 8'h03);
      neg_set <= 1'b0;
      wr_reg(8'h7b, 8'h01);
      wr_reg(8'h7a, 8'ha0);
      for (i = 1; i < 8; i++) begin
         @(posedge clk) trig_flags <= 7'h00;
         wr_reg(8'h7b, i[7:0]);
         trig_flags[i] <= 1'b1;
         wait_conv(1'b1);
      end
      @(posedge clk) trig_flags <= 7'h02;
      wr_reg(8'h7b, 8'h02);
      wait_conv(1'b1);
      wr_reg(8'h7b, 8'h00);
      wait_conv(1'b0);
      @(posedge clk) trig_flags <= 7'h00;
      wr_reg(8'h7a, 8'h80);
      wr_reg(8'h7b, 8'h01);
      trig_flags <= 7'h01;
      wait_conv(1'b0);
      wr_reg(8'h7a, 8'h8d);
      wr_reg(8'h7c, 8'h1f);
      wr_reg(8'h77, 8'h01);
      #1 chk({cen, irq_en, psel, mux, isrc}, 11'h77f);
      wrap_up();
   end
endmodule : test_adc_result_regs

bind adc_result_regs adc_regs_chk #(.PINS(PINS)) chk_i (.clk(clk), .reset(reset), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_done(conv_done),
   .done_flag_ack(done_flag_ack), .pin_read(pin_read), .pin_buffer_off(pin_buffer_off),
   .conv_start(conv_start), .conv_busy(conv_busy), .converter_enable(converter_enable),
   .conversion_done_flag(conversion_done_flag), .ext_ref_input_enable(ext_ref_input_enable),
   .int_ref_output_enable(int_ref_output_enable));
